// ===== logic/ssp_defs.svh
`ifndef SSP_DEFS_SVH
`define SSP_DEFS_SVH

// ==========================================================================
// Register map of the receive routing bytes
// ==========================================================================
`define SSP_ADDR_CH6        8'h2D
`define SSP_ADDR_CH7        8'h2E
`define SSP_RST_CH6         7'h05
`define SSP_RST_CH7         7'h06
`define SSP_RDATA_IDLE      8'h00
`define SSP_RSVD_BIT        1'h0

// ==========================================================================
// Source select codes
// ==========================================================================
`define SSP_SRC_OFF         2'h0
`define SSP_SRC_PLAY        2'h1
`define SSP_SRC_ADC         2'h2
`define SSP_SRC_LINK        2'h3

// ==========================================================================
// Destination numbers per channel and source
// ==========================================================================
`define SSP_DEST_NONE       4'h0
`define SSP_DEST_PLAY_CH6   4'h6
`define SSP_DEST_PLAY_CH7   4'h7
`define SSP_DEST_ADC_CH6    4'h2
`define SSP_DEST_ADC_CH7    4'h3
`define SSP_DEST_LINK_CH6   4'h1
`define SSP_DEST_LINK_CH7   4'h2

// ==========================================================================
// Frame geometry
// ==========================================================================
`define SSP_TDM_SLOTS       6'h20
`define SSP_HALF_SLOTS      6'h10
`define SSP_SLOT_SAT        6'h3F
`define SSP_SLOT_W_MIN      16
`define SSP_SLOT_W_MAX      32

`endif

// ===== logic/ssp_pkg.sv
package ssp_pkg;

    // ======================================================================
    // Types
    // ======================================================================
    typedef enum logic [1:0] {
        SSP_FMT_TDM = 2'h0,
        SSP_FMT_I2S = 2'h1,
        SSP_FMT_LJ  = 2'h2
    } ssp_fmt_type;

    typedef enum logic [1:0] {
        SSP_HUNT = 2'b01,
        SSP_RUN  = 2'b10
    } ssp_phase_type;

    typedef struct packed {
        logic [1:0] source;
        logic [4:0] slot;
    } ssp_route_type;

    typedef struct packed {
        logic        chan7;
        logic [1:0]  source;
        logic [3:0]  dest;
        logic [31:0] data;
    } ssp_word_type;

    typedef struct packed {
        ssp_phase_type phase;
        ssp_route_type cfg6;
        ssp_route_type cfg7;
        logic [7:0]    rdata;
        logic          bclk_d;
        logic          fs_d;
        logic          right;
        logic [4:0]    bit_cnt;
        logic [5:0]    slot_cnt;
        logic [31:0]   shreg;
        logic          pend6;
        logic          pend7;
        ssp_word_type  w6;
        ssp_word_type  w7;
        logic          overrun;
    } ssp_state_type;

endpackage : ssp_pkg

// ===== logic/ssp_sync.sv
module ssp_sync #(
    parameter int W = 3
) (
    input  wire logic         sys_clk_i,
    input  wire logic         rst_n_i,
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);

    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } ssp_sync_state_type;

    ssp_sync_state_type q;
    ssp_sync_state_type n;

    // ======================================================================
    // Two-stage synchroniser; the first stage feeds only the second
    // ======================================================================
    always_comb begin
        n.s1 = d_i;
        n.s2 = q.s1;
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            q <= '0;
        end else begin
            q <= n;
        end
    end

    assign q_o = q.s2;

endmodule : ssp_sync

// ===== logic/ssp_buf.sv
module ssp_buf #(
    parameter int W = 39
) (
    input  wire logic         sys_clk_i,
    input  wire logic         rst_n_i,
    input  wire logic         in_valid_i,
    output logic              in_ready_o,
    input  wire logic [W-1:0] in_data_i,
    output logic              out_valid_o,
    input  wire logic         out_ready_i,
    output logic      [W-1:0] out_data_o
);

    typedef struct packed {
        logic [W-1:0] e0;
        logic [W-1:0] e1;
        logic         v0;
        logic         v1;
    } ssp_buf_state_type;

    ssp_buf_state_type q;
    ssp_buf_state_type n;
    logic              push;
    logic              pop;

    // ======================================================================
    // Two-entry buffer; entry 0 is the head and drives the output
    // ======================================================================
    assign push = in_valid_i & ~q.v1;
    assign pop  = q.v0 & out_ready_i;

    always_comb begin
        n = q;
        if (pop) begin
            n.e0 = q.e1;
            n.v0 = q.v1;
            n.v1 = 1'b0;
        end
        if (push) begin
            if (!n.v0) begin
                n.e0 = in_data_i;
                n.v0 = 1'b1;
            end else begin
                n.e1 = in_data_i;
                n.v1 = 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            q <= '0;
        end else begin
            q <= n;
        end
    end

    // Full only when both entries hold data; a pop in the same cycle
    // does not open the gate, which costs one cycle but keeps it simple
    assign in_ready_o  = ~q.v1;
    assign out_valid_o = q.v0;
    assign out_data_o  = q.e0;

endmodule : ssp_buf

// ===== logic/ssp_rx_route.sv
// Operation
// - Bit 7 reserved, reads zero, writes dropped
// - Channel 6 source: off, playback, ADC2, link1
// - Channel 7 source: off, playback, ADC3, link2
// - TDM: slot value is slot index 0-31
// - I2S/LJ: values 0-15 select left slots
// - I2S/LJ: values 16-31 select right slots
// - Channel 6 byte at 0x2D resets 0x05
// - Channel 7 byte at 0x2E resets 0x06
`include "ssp_defs.svh"

module ssp_rx_route
    import ssp_pkg::*;
#(
    parameter int SLOT_W = 32
) (
    input  wire logic         sys_clk_i,
    input  wire logic         rst_n_i,
    input  wire logic [7:0]   reg_addr_i,
    input  wire logic [7:0]   reg_wdata_i,
    input  wire logic         reg_wr_i,
    input  wire logic         reg_rd_i,
    output logic      [7:0]   reg_rdata_o,
    input  wire ssp_fmt_type  fmt_i,
    input  wire logic         bclk_i,
    input  wire logic         fsync_i,
    input  wire logic         sdin_i,
    output logic              rx_valid_o,
    input  wire logic         rx_ready_i,
    output ssp_word_type      rx_word_o,
    output logic              rx_overrun_o
);

    // ======================================================================
    // Elaboration checks
    // ======================================================================
    generate
        if (SLOT_W < `SSP_SLOT_W_MIN || SLOT_W > `SSP_SLOT_W_MAX) begin : g_chk
            $error("ssp_rx_route: SLOT_W must lie in 16..32");
        end
    endgenerate

    // ======================================================================
    // Constants
    // ======================================================================
    localparam logic [4:0] LAST_BIT = 5'(SLOT_W - 1);

    // Short slots leave bits of the slot before in the shifter; the mask
    // clears them so that a word is the slot alone, right-aligned
    localparam logic [31:0] DATA_MASK = 32'({SLOT_W{1'b1}});

    // Both channels wake up disabled on their own default slot
    localparam ssp_state_type ST_RST = '{
        phase:    SSP_HUNT,
        cfg6:     ssp_route_type'(`SSP_RST_CH6),
        cfg7:     ssp_route_type'(`SSP_RST_CH7),
        rdata:    `SSP_RDATA_IDLE,
        bclk_d:   1'b0,
        fs_d:     1'b0,
        right:    1'b0,
        bit_cnt:  5'h00,
        slot_cnt: 6'h00,
        shreg:    32'h0000_0000,
        pend6:    1'b0,
        pend7:    1'b0,
        w6:       '0,
        w7:       '0,
        overrun:  1'b0
    };

    // ======================================================================
    // Destination number for a channel and its source code
    // ======================================================================
    function automatic logic [3:0] dest_of(input logic       chan7,
                                           input logic [1:0] src);
        logic [3:0] d;
        d = `SSP_DEST_NONE;
        case (src)
            `SSP_SRC_PLAY: d = chan7 ? `SSP_DEST_PLAY_CH7
                                     : `SSP_DEST_PLAY_CH6;
            `SSP_SRC_ADC:  d = chan7 ? `SSP_DEST_ADC_CH7
                                     : `SSP_DEST_ADC_CH6;
            `SSP_SRC_LINK: d = chan7 ? `SSP_DEST_LINK_CH7
                                     : `SSP_DEST_LINK_CH6;
            default:       d = `SSP_DEST_NONE;
        endcase
        return d;
    endfunction : dest_of

    // ======================================================================
    // Pin synchronisers
    // ======================================================================
    logic [2:0] pin_s;

    ssp_sync #(
        .W (3)
    ) u_sync (
        .sys_clk_i (sys_clk_i),
        .rst_n_i   (rst_n_i),
        .d_i       ({sdin_i, fsync_i, bclk_i}),
        .q_o       (pin_s)
    );

    // fmt_i comes from this clock domain and needs no synchroniser
    logic bclk_s;
    logic fs_s;
    logic din_s;

    assign bclk_s = pin_s[0];
    assign fs_s   = pin_s[1];
    assign din_s  = pin_s[2];

    // ======================================================================
    // State
    // ======================================================================
    ssp_state_type q;
    ssp_state_type n;

    logic          rise;
    logic          start;
    logic          take;
    logic          done;
    logic [31:0]   word;
    logic [4:0]    code;
    logic          code_ok;
    logic          hit6;
    logic          hit7;
    logic          buf_in_valid;
    logic          buf_in_ready;
    ssp_word_type  buf_in_word;

    assign rise = bclk_s & ~q.bclk_d;

    // Slot code of the word that finishes now, in register encoding
    always_comb begin
        if (fmt_i == SSP_FMT_TDM) begin
            code    = q.slot_cnt[4:0];
            code_ok = (q.slot_cnt < `SSP_TDM_SLOTS);
        end else begin
            code    = {q.right, q.slot_cnt[3:0]};
            code_ok = (q.slot_cnt < `SSP_HALF_SLOTS);
        end
    end

    assign word = {q.shreg[30:0], din_s};

    // ======================================================================
    // Strobes of this cycle: frame edge, bit taken, slot done, slot match
    // ======================================================================
    always_comb begin
        start = 1'b0;
        take  = 1'b0;
        if (rise) begin
            if (fmt_i == SSP_FMT_TDM) begin
                start = fs_s & ~q.fs_d;
            end else begin
                start = fs_s ^ q.fs_d;
            end
            if (start) begin
                // I2S carries one dead bit after the frame edge
                take = (fmt_i != SSP_FMT_I2S);
            end else begin
                take = (q.phase == SSP_RUN);
            end
        end

        // A frame edge clears the bit count, so it never ends a slot
        done = take && !start && (q.bit_cnt == LAST_BIT);

        hit6 = done && code_ok && q.cfg6.slot == code
            && q.cfg6.source != `SSP_SRC_OFF;
        hit7 = done && code_ok && q.cfg7.slot == code
            && q.cfg7.source != `SSP_SRC_OFF;
    end

    // Channel 6 is offered before channel 7 when both wait
    assign buf_in_valid = q.pend6 | q.pend7;
    assign buf_in_word  = q.pend6 ? q.w6 : q.w7;

    // ======================================================================
    // Next state
    // ======================================================================
    always_comb begin
        n        = q;
        n.bclk_d = bclk_s;

        // Register port; reads return the old value on a same-cycle write
        // Bit 7 of the write data is reserved and never stored
        if (reg_wr_i) begin
            case (reg_addr_i)
                `SSP_ADDR_CH6: n.cfg6 = ssp_route_type'(reg_wdata_i[6:0]);
                `SSP_ADDR_CH7: n.cfg7 = ssp_route_type'(reg_wdata_i[6:0]);
                default: ;
            endcase
        end
        if (reg_rd_i) begin
            case (reg_addr_i)
                `SSP_ADDR_CH6: n.rdata = {`SSP_RSVD_BIT, q.cfg6};
                `SSP_ADDR_CH7: n.rdata = {`SSP_RSVD_BIT, q.cfg7};
                default:       n.rdata = `SSP_RDATA_IDLE;
            endcase
        end

        // Framing, one step per bit clock rising edge
        if (rise) begin
            n.fs_d = fs_s;
            if (start) begin
                n.phase    = SSP_RUN;
                n.slot_cnt = 6'h00;
                n.bit_cnt  = 5'h00;
                case (fmt_i)
                    SSP_FMT_LJ:  n.right = ~fs_s;
                    SSP_FMT_I2S: n.right = fs_s;
                    default:     n.right = 1'b0;
                endcase
            end else begin
                // A corrupted phase falls back to hunting for a frame
                case (q.phase)
                    SSP_HUNT: n.phase = SSP_HUNT;
                    SSP_RUN:  n.phase = SSP_RUN;
                    default:  n.phase = SSP_HUNT;
                endcase
            end
        end

        if (take) begin
            n.shreg = word;
            if (done) begin
                n.bit_cnt  = 5'h00;
                // Saturate so that surplus slots never alias low ones
                if (n.slot_cnt != `SSP_SLOT_SAT) begin
                    n.slot_cnt = n.slot_cnt + 6'h01;
                end
            end else begin
                n.bit_cnt = n.bit_cnt + 5'h01;
            end
        end

        // Hand-off to the buffer; it takes at most one word a cycle
        if (buf_in_valid && buf_in_ready) begin
            if (q.pend6) begin
                n.pend6 = 1'b0;
            end else begin
                n.pend7 = 1'b0;
            end
        end

        // A word that finds its channel still waiting replaces the old one
        // Overrun is sticky; only reset clears it
        if (hit6) begin
            if (n.pend6) begin
                n.overrun = 1'b1;
            end
            n.pend6 = 1'b1;
            n.w6    = '{chan7:  1'b0,
                        source: q.cfg6.source,
                        dest:   dest_of(1'b0, q.cfg6.source),
                        data:   word & DATA_MASK};
        end
        if (hit7) begin
            if (n.pend7) begin
                n.overrun = 1'b1;
            end
            n.pend7 = 1'b1;
            n.w7    = '{chan7:  1'b1,
                        source: q.cfg7.source,
                        dest:   dest_of(1'b1, q.cfg7.source),
                        data:   word & DATA_MASK};
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            q <= ST_RST;
        end else begin
            q <= n;
        end
    end

    // ======================================================================
    // Output buffer; a stalled receiver holds two words without loss
    // ======================================================================
    logic [$bits(ssp_word_type)-1:0] buf_out;

    ssp_buf #(
        .W ($bits(ssp_word_type))
    ) u_buf (
        .sys_clk_i   (sys_clk_i),
        .rst_n_i     (rst_n_i),
        .in_valid_i  (buf_in_valid),
        .in_ready_o  (buf_in_ready),
        .in_data_i   (buf_in_word),
        .out_valid_o (rx_valid_o),
        .out_ready_i (rx_ready_i),
        .out_data_o  (buf_out)
    );

    assign rx_word_o    = ssp_word_type'(buf_out);
    assign reg_rdata_o  = q.rdata;
    assign rx_overrun_o = q.overrun;

endmodule : ssp_rx_route

// ===== test/ssp_host_model.sv
module ssp_host_model
    import ssp_pkg::*;
(
    output logic bclk_o,
    output logic fsync_o,
    output logic sdin_o
);
    timeunit 1ns;
    timeprecision 1ns;

    // ==============================
    // Frame source
    // ==============================
    initial begin
        bclk_o = 1'b0;
        fsync_o = 1'b0;
        sdin_o = 1'b0;
    end

    function automatic logic [15:0] slot_data(input logic h,
                                              input logic [4:0] s);
        return {8'h5A, h, 2'h0, s};
    endfunction : slot_data

    // Lines change while the clock is low; it stands still between frames
    task automatic bit_out(input logic fs, input logic d);
        fsync_o = fs;
        sdin_o = d;
        #62;
        bclk_o = 1'b1;
        #63;
        bclk_o = 1'b0;
    endtask : bit_out

    task automatic half_out(input logic fs, input logic h, input int n,
                            input logic lead, input logic pulse);
        logic [15:0] w;
        if (lead) begin
            bit_out(fs, ~sdin_o);
        end
        for (int s = 0; s < n; s++) begin
            w = slot_data(h, s[4:0]);
            for (int b = 15; b >= 0; b--) begin
                bit_out(pulse ? (s == 0 && b == 15) : fs, w[b]);
            end
        end
    endtask : half_out

    task automatic frame_out(input ssp_fmt_type f, input int n);
        // Pins never move in the time step of a system clock edge
        #2;
        case (f)
            SSP_FMT_TDM: half_out(1'b1, 1'b0, n, 1'b0, 1'b1);
            SSP_FMT_LJ: begin
                half_out(1'b1, 1'b0, n, 1'b0, 1'b0);
                half_out(1'b0, 1'b1, n, 1'b0, 1'b0);
            end
            default: begin
                // Stub half so that the left half opens on a falling edge
                bit_out(1'b1, 1'b0);
                half_out(1'b0, 1'b0, n, 1'b1, 1'b0);
                half_out(1'b1, 1'b1, n, 1'b1, 1'b0);
            end
        endcase
        // Data line no longer holds a valid bit after the frame
        sdin_o = ~sdin_o;
    endtask : frame_out
endmodule : ssp_host_model

// ===== test/ssp_rx_route_chk.sv
module ssp_rx_route_chk
    import ssp_pkg::*;
(
    input wire logic         sys_clk_i,
    input wire logic         rst_n_i,
    input wire logic [7:0]   reg_addr_i,
    input wire logic [7:0]   reg_wdata_i,
    input wire logic         reg_wr_i,
    input wire logic         reg_rd_i,
    input wire logic [7:0]   reg_rdata_o,
    input wire logic         rx_valid_o,
    input wire logic         rx_ready_i,
    input wire ssp_word_type rx_word_o,
    input wire logic         rx_overrun_o
);
    timeunit 1ns;
    timeprecision 1ns;

    // ==============================
    // Shadow of the routing bytes
    // ==============================
    logic [6:0] sh6_q;
    logic [6:0] sh7_q;

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            sh6_q <= 7'h05;
            sh7_q <= 7'h06;
        end else if (reg_wr_i && reg_addr_i == 8'h2D) begin
            sh6_q <= reg_wdata_i[6:0];
        end else if (reg_wr_i && reg_addr_i == 8'h2E) begin
            sh7_q <= reg_wdata_i[6:0];
        end
    end

    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (!rst_n_i);

    // ==============================
    // Assertions
    // ==============================
    rsvd_bit_a: assert property (reg_rdata_o[7] == 1'b0)
        else $error("reserved bit read as one");
    ch6_read_a: assert property (reg_rd_i && reg_addr_i == 8'h2D
        |=> reg_rdata_o == {1'b0, $past(sh6_q)})
        else $error("channel 6 byte read back wrong");
    ch7_read_a: assert property (reg_rd_i && reg_addr_i == 8'h2E
        |=> reg_rdata_o == {1'b0, $past(sh7_q)})
        else $error("channel 7 byte read back wrong");
    free_read_a: assert property (reg_rd_i && reg_addr_i != 8'h2D
        && reg_addr_i != 8'h2E |=> reg_rdata_o == 8'h00)
        else $error("unmapped read not zero");
    src_live_a: assert property (rx_valid_o
        |-> rx_word_o.source != 2'h0)
        else $error("word offered from a disabled channel");
    dest_map_a: assert property (rx_valid_o |-> rx_word_o.dest ==
        (rx_word_o.source == 2'h1 ? 4'h6 : rx_word_o.source == 2'h2 ?
        4'h2 : 4'h1) + {3'h0, rx_word_o.chan7})
        else $error("destination does not match source");
    word_hold_a: assert property (rx_valid_o && !rx_ready_i
        |=> rx_valid_o && $stable(rx_word_o))
        else $error("offered word dropped or changed");
    ovr_stick_a: assert property (rx_overrun_o |=> rx_overrun_o)
        else $error("overrun flag cleared");
endmodule : ssp_rx_route_chk

bind ssp_rx_route ssp_rx_route_chk ssp_rx_route_chk_inst (
    .sys_clk_i   (sys_clk_i),
    .rst_n_i     (rst_n_i),
    .reg_addr_i  (reg_addr_i),
    .reg_wdata_i (reg_wdata_i),
    .reg_wr_i    (reg_wr_i),
    .reg_rd_i    (reg_rd_i),
    .reg_rdata_o (reg_rdata_o),
    .rx_valid_o  (rx_valid_o),
    .rx_ready_i  (rx_ready_i),
    .rx_word_o   (rx_word_o),
    .rx_overrun_o(rx_overrun_o)
);

// ===== test/test_ssp_rx_route.sv
module test_ssp_rx_route
    import ssp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    logic         sys_clk_i = 1'b0;
    logic         rst_n_i;
    logic [7:0]   reg_addr_i;
    logic [7:0]   reg_wdata_i;
    logic         reg_wr_i;
    logic         reg_rd_i;
    logic [7:0]   reg_rdata_o;
    ssp_fmt_type  fmt_i;
    logic         bclk;
    logic         fsync;
    logic         sdin;
    logic         rx_valid_o;
    logic         rx_ready_i;
    ssp_word_type rx_word_o;
    logic         rx_overrun_o;
    int           err_total;
    int           check_count;

    always #5 sys_clk_i = ~sys_clk_i;

    ssp_host_model ssp_host_model_inst (
        .bclk_o (bclk),
        .fsync_o(fsync),
        .sdin_o (sdin)
    );

    ssp_rx_route #(.SLOT_W(16)) ssp_rx_route_inst (
        .sys_clk_i   (sys_clk_i),
        .rst_n_i     (rst_n_i),
        .reg_addr_i  (reg_addr_i),
        .reg_wdata_i (reg_wdata_i),
        .reg_wr_i    (reg_wr_i),
        .reg_rd_i    (reg_rd_i),
        .reg_rdata_o (reg_rdata_o),
        .fmt_i       (fmt_i),
        .bclk_i      (bclk),
        .fsync_i     (fsync),
        .sdin_i      (sdin),
        .rx_valid_o  (rx_valid_o),
        .rx_ready_i  (rx_ready_i),
        .rx_word_o   (rx_word_o),
        .rx_overrun_o(rx_overrun_o)
    );

    // ==============================
    // Access and compare tasks
    // ==============================
    task automatic stop_test;
        $display("checks %0d errors %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : stop_test

    task automatic check_val(input logic [23:0] got, input logic [23:0] exp);
        check_count++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t: got %h exp %h", $time, got, exp);
        end
    endtask : check_val

    task automatic check_word(input logic [39:0] got,
                              input logic [39:0] exp);
        check_count++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t: word %h exp %h", $time, got, exp);
        end
    endtask : check_word

    task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge sys_clk_i);
        reg_wr_i <= 1'b0;
    endtask : reg_write

    task automatic reg_read(input logic [7:0] a, input logic [7:0] e);
        @(posedge sys_clk_i);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge sys_clk_i);
        reg_rd_i <= 1'b0;
        @(negedge sys_clk_i);
        check_val({16'h0, reg_rdata_o}, {16'h0, e});
    endtask : reg_read

    task automatic do_reset(input ssp_fmt_type f);
        @(posedge sys_clk_i);
        rst_n_i <= 1'b0;
        fmt_i <= f;
        // Three edges so the pin synchronisers flush
        repeat (3) @(posedge sys_clk_i);
        rst_n_i <= 1'b1;
    endtask : do_reset

    function automatic logic [6:0] exp_tag(input logic c,
                                           input logic [1:0] s);
        logic [3:0] d;
        d = (s == 2'h1 ? 4'h6 : s == 2'h2 ? 4'h2 : 4'h1) + {3'h0, c};
        return {c, s, d};
    endfunction : exp_tag

    task automatic take(input logic [6:0] t, input logic [15:0] v);
        int n;
        n = 0;
        do begin
            @(negedge sys_clk_i);
            n++;
        end while (rx_valid_o !== 1'b1 && n < 20000);
        check_word({rx_valid_o, rx_word_o}, {1'b1, t, 16'h0000, v});
        if (n >= 20000) begin
            stop_test();
        end else begin
            @(posedge sys_clk_i);
            rx_ready_i <= 1'b1;
            @(posedge sys_clk_i);
            rx_ready_i <= 1'b0;
        end
    endtask : take

    // ==============================
    // Scenarios
    // ==============================
    initial begin
        rst_n_i = 1'b0;
        reg_addr_i = 8'h00;
        reg_wdata_i = 8'h00;
        reg_wr_i = 1'b0;
        reg_rd_i = 1'b0;
        rx_ready_i = 1'b0;
        fmt_i = SSP_FMT_TDM;
        err_total = 0;
        check_count = 0;
        repeat (2) @(posedge sys_clk_i);
        rst_n_i <= 1'b1;
        reg_read(8'h2D, 8'h05);
        reg_read(8'h2E, 8'h06);
        reg_read(8'h2F, 8'h00);
        ssp_host_model_inst.frame_out(SSP_FMT_TDM, 8);
        repeat (20) @(negedge sys_clk_i);
        check_val({23'h0, rx_valid_o}, 24'h0);
        reg_write(8'h2D, 8'hFF);
        reg_read(8'h2D, 8'h7F);
        // Slot 31 and slot 0 are the ends of the TDM range
        for (int s = 1; s < 4; s++) begin
            reg_write(8'h2D, {1'b1, s[1:0], 5'h1F});
            reg_write(8'h2E, {1'b0, s[1:0], 5'h00});
            ssp_host_model_inst.frame_out(SSP_FMT_TDM, 32);
            take(exp_tag(1'b1, s[1:0]),
                 ssp_host_model_inst.slot_data(1'b0, 5'h00));
            take(exp_tag(1'b0, s[1:0]),
                 ssp_host_model_inst.slot_data(1'b0, 5'h1F));
        end
        // Receiver stalls for three frames: buffer and holds fill up
        reg_write(8'h2D, 8'h21);
        reg_write(8'h2E, 8'h43);
        @(negedge sys_clk_i);
        check_val({23'h0, rx_overrun_o}, 24'h0);
        repeat (3) ssp_host_model_inst.frame_out(SSP_FMT_TDM, 4);
        repeat (2) begin
            take(exp_tag(1'b0, 2'h1),
                 ssp_host_model_inst.slot_data(1'b0, 5'h01));
            take(exp_tag(1'b1, 2'h2),
                 ssp_host_model_inst.slot_data(1'b0, 5'h03));
        end
        repeat (4) @(negedge sys_clk_i);
        check_val({22'h0, rx_valid_o, rx_overrun_o}, 24'h1);
        do_reset(SSP_FMT_LJ);
        reg_read(8'h2E, 8'h06);
        check_val({23'h0, rx_overrun_o}, 24'h0);
        reg_write(8'h2D, 8'h31);
        reg_write(8'h2E, 8'h22);
        ssp_host_model_inst.frame_out(SSP_FMT_LJ, 3);
        take(exp_tag(1'b1, 2'h1),
             ssp_host_model_inst.slot_data(1'b0, 5'h02));
        take(exp_tag(1'b0, 2'h1),
             ssp_host_model_inst.slot_data(1'b1, 5'h01));
        do_reset(SSP_FMT_I2S);
        reg_write(8'h2D, 8'h50);
        reg_write(8'h2E, 8'h60);
        ssp_host_model_inst.frame_out(SSP_FMT_I2S, 2);
        take(exp_tag(1'b1, 2'h3),
             ssp_host_model_inst.slot_data(1'b0, 5'h00));
        take(exp_tag(1'b0, 2'h2),
             ssp_host_model_inst.slot_data(1'b1, 5'h00));
        stop_test();
    end
endmodule : test_ssp_rx_route
